// [ipf_top.v]
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "ipf_consts.vh"
// Summary of operation
// R1 - fault A priority in bits 10..8
// R2 - main PWM priority in bits 6..4
// R3 - field value is priority level 1..7
// R4 - zero field disables its source
// R5 - unimplemented bits read zero, ignore writes
// R6 - serial error priority bits 6..4, reset 100
module ipf_top (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [2:0]  src_flag,
  input  wire [2:0]  src_enable,
  output wire [2:0]  src_request,
  output wire [8:0]  src_level
);

  // source slots in the packed priority bus
  localparam PRIO_W      = 3;
  localparam N_SRC       = 3;
  localparam SRC_SERIAL  = 0;
  localparam SRC_FAULT_A = 1;
  localparam SRC_MAIN    = 2;

  // reset release path
  reg         rst_s1;
  reg         rst_s2;
  wire        rst_int_b;

  // priority fields and their next values
  reg  [2:0]  serial_error_prio;
  reg  [2:0]  pwm2_fault_a_prio;
  reg  [2:0]  pwm2_main_prio;
  reg  [2:0]  next_serial_error_prio;
  reg  [2:0]  next_pwm2_fault_a_prio;
  reg  [2:0]  next_pwm2_main_prio;

  // bus decode
  reg         hit_serial;
  reg         hit_pwm2;
  reg         wr_serial;
  reg         wr_fault_a;
  reg         wr_main;
  reg         rd_serial;
  reg         rd_pwm2;

  // read views of the two registers
  reg  [15:0] view_serial;
  reg  [15:0] view_pwm2;
  reg  [15:0] next_rdata;

  // fields side by side for the gates
  wire [8:0]  prio_all;
  genvar      g;

  // two-flop release, all fields leave reset on one edge
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  assign rst_int_b = rst_s2;

  // unmapped offsets hit nothing
  always @* begin
    hit_serial = 1'b0;
    hit_pwm2   = 1'b0;
    case (addr)
      `IPF_ADDR_SERIAL: begin
        hit_serial = 1'b1;
      end
      `IPF_ADDR_PWM2: begin
        hit_pwm2 = 1'b1;
      end
      default: begin
        hit_serial = 1'b0; // R5
        hit_pwm2   = 1'b0; // R5
      end
    endcase
  end

  // write enables per field, none for unmapped offsets
  always @* begin
    wr_serial  = 1'b0;
    wr_fault_a = 1'b0;
    wr_main    = 1'b0;
    if (wr) begin
      wr_serial  = hit_serial;
      wr_fault_a = hit_pwm2;
      wr_main    = hit_pwm2;
    end
  end

  // read selects, at most one high
  always @* begin
    rd_serial = 1'b0;
    rd_pwm2   = 1'b0;
    if (rd) begin
      rd_serial = hit_serial;
      rd_pwm2   = hit_pwm2;
    end
  end

  // serial error field takes bits 6..4 only
  always @* begin
    if (wr_serial) begin
      next_serial_error_prio = wdata[`IPF_SERIAL_MSB:`IPF_SERIAL_LSB]; // R6
    end else begin
      next_serial_error_prio = serial_error_prio;
    end
  end

  // fault A field of the second register
  always @* begin
    if (wr_fault_a) begin
      next_pwm2_fault_a_prio = wdata[`IPF_FAULT_A_MSB:`IPF_FAULT_A_LSB]; // R1
    end else begin
      next_pwm2_fault_a_prio = pwm2_fault_a_prio;
    end
  end

  // main PWM field of the second register
  always @* begin
    if (wr_main) begin
      next_pwm2_main_prio = wdata[`IPF_MAIN_MSB:`IPF_MAIN_LSB]; // R2
    end else begin
      next_pwm2_main_prio = pwm2_main_prio;
    end
  end

  // field flops, reset gives the power-on levels
  always @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      serial_error_prio <= `IPF_SERIAL_RST; // R6
    end else begin
      serial_error_prio <= next_serial_error_prio;
    end
  end

  always @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      pwm2_fault_a_prio <= `IPF_FAULT_A_RST;
    end else begin
      pwm2_fault_a_prio <= next_pwm2_fault_a_prio;
    end
  end

  always @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      pwm2_main_prio <= `IPF_MAIN_RST;
    end else begin
      pwm2_main_prio <= next_pwm2_main_prio;
    end
  end

  // unimplemented positions stay low in both views
  always @* begin
    view_serial = 16'h0000; // R5
    view_serial[`IPF_SERIAL_MSB:`IPF_SERIAL_LSB] = serial_error_prio; // R6
  end

  // second register: fault A high, main PWM low
  always @* begin
    view_pwm2 = 16'h0000; // R5
    view_pwm2[`IPF_FAULT_A_MSB:`IPF_FAULT_A_LSB] = pwm2_fault_a_prio; // R1
    view_pwm2[`IPF_MAIN_MSB:`IPF_MAIN_LSB]       = pwm2_main_prio; // R2
  end

  // read data stand one cycle, zero otherwise
  always @* begin
    next_rdata = 16'h0000;
    case ({rd_pwm2, rd_serial})
      2'b01: begin
        next_rdata = view_serial;
      end
      2'b10: begin
        next_rdata = view_pwm2;
      end
      default: begin
        next_rdata = 16'h0000; // R5
      end
    endcase
  end

  // registered read port
  always @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // packed as source index times field width
  assign prio_all[PRIO_W*SRC_SERIAL+PRIO_W-1:PRIO_W*SRC_SERIAL]   = serial_error_prio;
  assign prio_all[PRIO_W*SRC_FAULT_A+PRIO_W-1:PRIO_W*SRC_FAULT_A] = pwm2_fault_a_prio;
  assign prio_all[PRIO_W*SRC_MAIN+PRIO_W-1:PRIO_W*SRC_MAIN]       = pwm2_main_prio;

  // one gate per source turns field and flag into request
  generate
    for (g = 0; g < N_SRC; g = g + 1) begin : gate
      ipf_prio_gate u_gate (
        .prio    (prio_all[PRIO_W*g+PRIO_W-1:PRIO_W*g]),
        .flag    (src_flag[g]),
        .enable  (src_enable[g]),
        .request (src_request[g]),
        .level   (src_level[PRIO_W*g+PRIO_W-1:PRIO_W*g])
      );
    end
  endgenerate
endmodule // ipf_top

// [ipf_consts.vh]
`ifndef IPF_CONSTS_VH
`define IPF_CONSTS_VH
// register offsets on the plain port
`define IPF_ADDR_SERIAL      4'h0
`define IPF_ADDR_PWM2        4'h1
// field positions
`define IPF_SERIAL_LSB       4
`define IPF_SERIAL_MSB       6
`define IPF_FAULT_A_LSB      8
`define IPF_FAULT_A_MSB      10
`define IPF_MAIN_LSB         4
`define IPF_MAIN_MSB         6
// reset values
`define IPF_SERIAL_RST       3'h4
`define IPF_FAULT_A_RST      3'h0
`define IPF_MAIN_RST         3'h4
`endif

// [ipf_prio_gate.v]
`timescale 1ns/10ps
// turns a priority field into a gated request with its level
module ipf_prio_gate (
  input  wire [2:0] prio,
  input  wire       flag,
  input  wire       enable,
  output wire       request,
  output wire [2:0] level
);
  assign request = flag & enable & (prio != 3'h0); // R4
  assign level   = prio; // R3
endmodule // ipf_prio_gate

// [ipf_core.sv]
`timescale 1ns/10ps
module ipf_core(input wire clock,output reg [3:0] addr,output reg [15:0] wdata,output reg wr,rd);
initial {addr,wdata,wr,rd}=0;
task put(input [3:0] a,input [15:0] d,input w);
@(posedge clock) {addr,wdata,wr,rd}<={a,d,w,!w};
@(posedge clock) {wdata,wr,rd}<={~d,2'b0};
endtask
endmodule // ipf_core

// [ipf_checker.sv]
`timescale 1ns/10ps
module ipf_checker(input wire clock,rst_b,rd,input wire [3:0] addr,input wire [15:0] rdata,
input wire [2:0] src_flag,src_enable,src_request,input wire [8:0] src_level);
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
a_req_gated: assert property(
src_request==(src_flag&src_enable&{|src_level[8:6],|src_level[5:3],|src_level[2:0]})) else $error("bad request");
a_rd_idle: assert property(!$past(rd) |-> rdata==0) else $error("rdata not idle");
a_unimpl_zero: assert property($past(rd) |-> (rdata&16'hf88f)==0) else $error("unimpl bits");
a_main_read: assert property($past(rd)&&$past(addr)==1 |-> rdata[6:4]==src_level[8:6]) else $error("main");
a_fault_read: assert property($past(rd)&&$past(addr)==1 |-> rdata[10:8]==src_level[5:3]) else $error("fa");
a_serial_read: assert property($past(rd)&&$past(addr)==0 |-> rdata==src_level[2:0]<<4) else $error("ser");
endmodule // ipf_checker
bind ipf_top ipf_checker chk_u(.clock,.rst_b,.rd,.addr,.rdata,.src_flag,.src_enable,.src_request,.src_level);

// [ipf_top_bench.sv]
`timescale 1ns/10ps
module ipf_top_bench;
reg clock=0,rst_b=0;reg [2:0] fl=0,en=0;reg [7:0] s=8'h52;reg [3:0] a;reg [15:0] d;
wire [3:0] addr;wire [15:0] wdata,rdata;wire wr,rd;wire [2:0] rq;wire [8:0] lv;
reg [15:0] q[$];reg [15:0] m[2]='{16'h40,16'h40};int error_cnt=0,n_checks=0;
wire [8:0] lv_x={m[1][6:4],m[1][10:8],m[0][6:4]};
wire [2:0] rq_x=fl&en&{|lv_x[8:6],|lv_x[5:3],|lv_x[2:0]};
always #2.5 clock=~clock;
ipf_core core_u(.clock,.addr,.wdata,.wr,.rd);
ipf_top dut_u(.clock,.rst_b,.addr,.wdata,.wr,.rd,.rdata,.src_flag(fl),.src_enable(en),.src_request(rq),.src_level(lv));
function [7:0] lf(input [7:0] x); lf={x[6:0],x[7]^x[5]^x[4]^x[3]}; endfunction
task chk(input [15:0] g,e);
n_checks++;
if(g!==e) begin error_cnt++; $display("ERROR %0t %h %h",$time,g,e); end
endtask
task stop_test;
$display("errors %0d checks %0d",error_cnt,n_checks);
if(error_cnt==0&&n_checks>0) $display("ALL TESTS PASSED");
else $display("TESTS FAILED");
$finish;
endtask
always @(posedge clock) if(rd) begin @(negedge clock); chk(rdata,q.pop_front()); end
initial begin #5000; error_cnt++; stop_test; end
initial begin
repeat(4) @(posedge clock); rst_b<=1; repeat(3) @(posedge clock);
@(negedge clock); chk({7'h0,lv},{7'h0,lv_x});
repeat(60) begin
s=lf(s); d={s,lf(s)}; a=s[1:0]; {fl,en}<=s[7:2];
q.push_back(a<2?m[a]:16'h0); core_u.put(a,0,0);
core_u.put(a,d,1); if(a<2) m[a]=d&(a?16'h0770:16'h0070);
@(negedge clock); chk({7'h0,lv},{7'h0,lv_x});
chk({13'h0,rq},{13'h0,rq_x});
end
repeat(2) @(posedge clock); stop_test;
end
endmodule // ipf_top_bench
